/* File: shared/scs_regs.svh */
// register offsets, field positions and timing counts of the serial link
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
// device registers, reached over the serial link
`define SCS_A_MIRROR 12'h010
`define SCS_A_HWCFG 12'h011
`define SCS_A_OPMODE 12'h012
`define SCS_A_STAT 12'h013
`define SCS_A_MASK 12'h014
`define SCS_A_APPLY 12'h900
`define SCS_OP_LOWPWR 1
`define SCS_OP_EXTERNAL_CLOCK_SELECT 4
`define SCS_CFG_RST 3'h0
`define SCS_CMD_WR 2'h2
`define SCS_ACK 8'h41
`define SCS_HDR1 8'hC1
`define SCS_HDR2 8'hC2
`define SCS_ST_USER 0
`define SCS_ST_WARM 1
`define SCS_ST_APPLY 2
`define SCS_WARM_CYC 65536
// host registers, word index on AXI4-Lite
`define SCS_H_ADDR_W 5
`define SCS_IDX_HI 4
`define SCS_IDX_LO 2
`define SCS_HR_CTRL 3'h0
`define SCS_HR_TX 3'h1
`define SCS_HR_RX 3'h2
`define SCS_HR_STAT 3'h3
`define SCS_HR_MASK 3'h4
`define SCS_RESP_OK 2'h0
`define SCS_RESP_ERR 2'h2
// timing
`define SCS_CLK_NS 8
`define SCS_SCLK_NS 160
`define SCS_HALF_CYC ((`SCS_SCLK_NS + 2 * `SCS_CLK_NS - 1) / (2 * `SCS_CLK_NS))
`define SCS_GAP_CLK 400
`define SCS_BYTE_EDGES 4'hF
`endif

/* File: shared/scs_pkg.sv */
// types shared by both ends of the serial link
package scs_pkg;
    typedef enum logic [2:0] {DEV_CMD, DEV_ADDR, DEV_WDATA, DEV_RACK, DEV_RDATA} scs_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SHIFT, H_HOLD, H_GAP} scs_host_state_t;
    typedef struct packed {
        logic sselHigh;
        logic cpha;
        logic cpol;
    } scs_cfg_t;
endpackage : scs_pkg

/* File: shared/scs_link_if.sv */
// serial link between the external master and the slave port
interface scs_link_if;
    logic sclk;
    logic ssel;
    logic mosi;
    logic misoOut;
    logic misoOe;
    logic miso;
    logic irqN;
    // undriven data line reads high
    assign miso = misoOe ? misoOut : 1'h1;
    modport device (input sclk, input ssel, input mosi, output misoOut, output misoOe, output irqN);
    modport host (output sclk, output ssel, output mosi, input miso, input irqN);
endinterface : scs_link_if

/* File: logic/scs_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
module scs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } scs_sync_reg_t;

    scs_sync_reg_t state_ff;
    scs_sync_reg_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.stage1 = asyncIn;
        nxt_state.stage2 = state_ff.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign syncOut = state_ff.stage2;
endmodule : scs_sync

/* File: logic/scs_device.sv */
// device end: serial slave port with format and clock-source select
`include "scs_regs.svh"

module scs_device #(
    parameter int WARM_CYC = `SCS_WARM_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic porRst,
    input wire logic oscInputPin,
    input wire logic userEvent,
    scs_link_if.device link,
    output scs_pkg::scs_cfg_t activeCfg,
    output logic externalClockSelect,
    output logic lowPowerMode,
    output logic oscEnable,
    output logic sysClkHf,
    output logic [7:0] rxByte,
    output logic rxValid
);
    import scs_pkg::*;

    localparam int CNT_W = $clog2(WARM_CYC + 1);

    typedef struct packed {
        scs_dev_state_t fsm;
        scs_cfg_t cfg;
        scs_cfg_t mirror;
        logic external_clock_select;
        logic lowPwr;
        logic [2:0] status;
        logic [2:0] mask;
        logic [1:0] cmd;
        logic [11:0] addr;
        logic [7:0] rdData;
        logic [2:0] bitCnt;
        logic [7:0] rxSh;
        logic [7:0] txByte;
        logic misoBit;
        logic misoOe;
        logic selPrev;
        logic sclkPrev;
        logic oscPrev;
        logic [CNT_W-1:0] warmCnt;
        logic hfReady;
        logic sysClkHf;
        logic oscEn;
        logic irqN;
        logic [7:0] rxByte;
        logic rxValid;
    } scs_dev_reg_t;

    scs_dev_reg_t s;
    scs_dev_reg_t n;
    logic [3:0] syncBits;
    logic oscS;
    logic sclkS;
    logic selRaw;
    logic mosiS;
    logic sel;
    logic actEdge;
    logic sampleEdge;
    logic [7:0] rxNew;
    logic [11:0] fullAddr;
    logic [2:0] evt;
    logic [2:0] clr;

    function automatic logic [7:0] readMux(input scs_dev_reg_t r, input logic [11:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `SCS_A_MIRROR: d = {5'h00, r.mirror};
            `SCS_A_HWCFG: d = {5'h00, r.cfg};
            `SCS_A_OPMODE: begin
                d[`SCS_OP_EXTERNAL_CLOCK_SELECT] = r.external_clock_select;
                d[`SCS_OP_LOWPWR] = r.lowPwr;
            end
            `SCS_A_STAT: d = {5'h00, r.status};
            `SCS_A_MASK: d = {5'h00, r.mask};
            default: d = 8'h00;
        endcase
        return d;
    endfunction : readMux

    scs_sync #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        // select inverted so reset reads as deselected, not a false frame
        .asyncIn({oscInputPin, link.sclk, ~link.ssel, link.mosi}),
        .syncOut(syncBits)
    );

    assign oscS = syncBits[3];
    assign sclkS = syncBits[2];
    assign selRaw = ~syncBits[1];
    assign mosiS = syncBits[0];

    assign sel = s.cfg.sselHigh ? selRaw : ~selRaw;
    assign actEdge = s.cfg.cpol ? (s.sclkPrev & ~sclkS) : (sclkS & ~s.sclkPrev);
    assign sampleEdge = s.cfg.cpha ? (sel & (sclkS ^ s.sclkPrev) & ~actEdge) : (sel & actEdge);
    assign rxNew = {s.rxSh[6:0], mosiS};
    assign fullAddr = {s.addr[11:8], rxNew};

    always_comb begin
        n = s;
        n.sclkPrev = sclkS;
        n.oscPrev = oscS;
        n.selPrev = sel;
        n.rxValid = 1'h0;
        evt = 3'h0;
        clr = 3'h0;
        evt[`SCS_ST_USER] = userEvent;
        if (oscS && !s.oscPrev && !s.hfReady) begin
            n.warmCnt = s.warmCnt + 1'h1;
            if (s.warmCnt == CNT_W'(WARM_CYC - 1)) begin
                n.hfReady = 1'h1;
                evt[`SCS_ST_WARM] = 1'h1;
            end
        end
        if (!sel) begin
            n.bitCnt = 3'h0;
            n.misoOe = 1'h0;
        end else begin
            n.misoOe = 1'h1;
            if (!s.selPrev && !s.cfg.cpha) begin
                n.misoBit = s.txByte[7];
            end
            if (actEdge && s.cfg.cpha) begin
                n.misoBit = s.txByte[3'h7 - s.bitCnt];
            end
            if (sampleEdge) begin
                n.rxSh = rxNew;
                n.bitCnt = s.bitCnt + 3'h1;
                if (!s.cfg.cpha) begin
                    n.misoBit = s.txByte[3'h6 - s.bitCnt];
                end
                if (s.bitCnt == 3'h7) begin
                    n.rxByte = rxNew;
                    n.rxValid = 1'h1;
                    // each byte answered by one byte
                    unique case (s.fsm)
                        DEV_CMD: begin
                            n.cmd = rxNew[7:6];
                            n.addr = {rxNew[3:0], 8'h00};
                            n.txByte = `SCS_HDR2;
                            n.fsm = DEV_ADDR;
                        end
                        DEV_ADDR: begin
                            n.addr = fullAddr;
                            n.txByte = `SCS_ACK;
                            if (s.cmd == `SCS_CMD_WR) begin
                                n.fsm = DEV_WDATA;
                            end else begin
                                n.fsm = DEV_RACK;
                                n.rdData = readMux(s, fullAddr);
                                if (fullAddr == `SCS_A_APPLY) begin
                                    n.cfg = s.mirror;
                                    evt[`SCS_ST_APPLY] = 1'h1;
                                end
                            end
                        end
                        DEV_WDATA: begin
                            n.txByte = `SCS_HDR1;
                            n.fsm = DEV_CMD;
                            case (s.addr)
                                `SCS_A_MIRROR: n.mirror = scs_cfg_t'(rxNew[2:0]);
                                `SCS_A_OPMODE: begin
                                    n.external_clock_select = s.external_clock_select | rxNew[`SCS_OP_EXTERNAL_CLOCK_SELECT];
                                    n.lowPwr = rxNew[`SCS_OP_LOWPWR];
                                end
                                `SCS_A_STAT: clr = rxNew[2:0];
                                `SCS_A_MASK: n.mask = rxNew[2:0];
                                default: n.mask = s.mask;
                            endcase
                        end
                        DEV_RACK: begin
                            n.txByte = s.rdData;
                            n.fsm = DEV_RDATA;
                        end
                        DEV_RDATA: begin
                            n.txByte = `SCS_HDR1;
                            n.fsm = DEV_CMD;
                        end
                    endcase
                    if (!s.cfg.cpha) begin
                        n.misoBit = n.txByte[7];
                    end
                end
            end
        end
        // set wins over a clear in the same cycle
        n.status = (s.status & ~clr) | evt;
        n.irqN = ~|(n.status & n.mask);
        // internal clock during warm-up or low power
        n.sysClkHf = n.hfReady & ~n.lowPwr;
        // crystal circuit off with external clock
        n.oscEn = ~n.external_clock_select;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || porRst) begin
            s <= '0;
            s.fsm <= DEV_CMD;
            s.cfg <= `SCS_CFG_RST;
            s.mirror <= `SCS_CFG_RST;
            s.txByte <= `SCS_HDR1;
            s.irqN <= 1'h1;
            s.external_clock_select <= s.external_clock_select & ~porRst;
            s.oscEn <= ~(s.external_clock_select & ~porRst);
        end else begin
            s <= n;
        end
    end

    assign link.misoOut = s.misoBit;
    assign link.misoOe = s.misoOe;
    assign link.irqN = s.irqN;
    assign activeCfg = s.cfg;
    assign externalClockSelect = s.external_clock_select;
    assign lowPowerMode = s.lowPwr;
    assign oscEnable = s.oscEn;
    assign sysClkHf = s.sysClkHf;
    assign rxByte = s.rxByte;
    assign rxValid = s.rxValid;
endmodule : scs_device

/* File: logic/scs_host.sv */
// host end: AXI4-Lite controlled master for the serial slave port
`include "scs_regs.svh"

module scs_host #(
    parameter int HALF_CYC = `SCS_HALF_CYC,
    parameter int GAP_CYC = `SCS_GAP_CLK
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`SCS_H_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SCS_H_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    scs_link_if.host link
);
    import scs_pkg::*;

    localparam int DIV_W = $clog2(HALF_CYC + 1);
    localparam int GAP_W = $clog2(GAP_CYC + 1);

    typedef struct packed {
        scs_host_state_t fsm;
        scs_cfg_t cfg;
        logic [1:0] sticky;
        logic [1:0] mask;
        logic awTaken;
        logic [2:0] awIdx;
        logic wTaken;
        logic [7:0] wData;
        logic wStrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [DIV_W-1:0] divCnt;
        logic [GAP_W-1:0] gapCnt;
        logic [3:0] edgeNum;
        logic [7:0] txSh;
        logic [7:0] rxSh;
        logic [7:0] rxData;
        logic sclk;
        logic sselPin;
        logic mosi;
        logic irq;
    } scs_host_reg_t;

    scs_host_reg_t s;
    scs_host_reg_t n;
    logic [1:0] syncBits;
    logic tick;
    logic selAct;
    logic [1:0] evt;
    logic [1:0] clr;

    scs_sync #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        // request inverted so a freshly reset synchroniser reads idle
        .asyncIn({link.miso, ~link.irqN}),
        .syncOut(syncBits)
    );

    // half period keeps clock within limit
    assign tick = (s.divCnt == DIV_W'(HALF_CYC - 1));

    always_comb begin
        n = s;
        evt = {syncBits[0], 1'h0};
        clr = 2'h0;
        n.divCnt = tick ? '0 : s.divCnt + 1'h1;
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'h0;
        end
        if (s_axi_awvalid && s.awready) begin
            n.awTaken = 1'h1;
            n.awIdx = s_axi_awaddr[`SCS_IDX_HI:`SCS_IDX_LO];
        end
        if (s_axi_wvalid && s.wready) begin
            n.wTaken = 1'h1;
            n.wData = s_axi_wdata[7:0];
            n.wStrb0 = s_axi_wstrb[0];
        end
        unique case (s.fsm)
            H_IDLE: begin
                n.edgeNum = 4'h0;
            end
            H_SETUP: begin
                if (tick) begin
                    n.fsm = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    n.sclk = ~s.sclk;
                    n.edgeNum = s.edgeNum + 4'h1;
                    // even edges are active; phase picks sampling edge
                    if (s.cfg.cpha == s.edgeNum[0]) begin
                        n.rxSh = {s.rxSh[6:0], syncBits[1]};
                    end else begin
                        n.mosi = s.txSh[7];
                        n.txSh = {s.txSh[6:0], 1'h0};
                    end
                    if (s.edgeNum == `SCS_BYTE_EDGES) begin
                        n.fsm = H_HOLD;
                    end
                end
            end
            H_HOLD: begin
                if (tick) begin
                    n.fsm = H_GAP;
                    n.rxData = s.rxSh;
                    n.gapCnt = '0;
                    evt[0] = 1'h1;
                end
            end
            H_GAP: begin
                n.gapCnt = s.gapCnt + 1'h1;
                if (s.gapCnt == GAP_W'(GAP_CYC - 1)) begin
                    n.fsm = H_IDLE;
                end
            end
        endcase
        if (n.awTaken && n.wTaken) begin
            n.awTaken = 1'h0;
            n.wTaken = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = `SCS_RESP_OK;
            case (n.awIdx)
                `SCS_HR_CTRL: begin
                    if (n.wStrb0) begin
                        n.cfg = scs_cfg_t'(n.wData[2:0]);
                    end
                end
                `SCS_HR_TX: begin
                    // only the master starts a byte
                    if (n.wStrb0 && s.fsm == H_IDLE) begin
                        n.fsm = H_SETUP;
                        n.divCnt = '0;
                        n.rxSh = 8'h00;
                        n.txSh = s.cfg.cpha ? n.wData : {n.wData[6:0], 1'h0};
                        n.mosi = s.cfg.cpha ? 1'h0 : n.wData[7];
                    end
                end
                `SCS_HR_STAT: clr = n.wStrb0 ? n.wData[2:1] : 2'h0;
                `SCS_HR_MASK: n.mask = n.wStrb0 ? n.wData[2:1] : s.mask;
                default: n.bresp = `SCS_RESP_ERR;
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'h0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'h1;
            n.rresp = `SCS_RESP_OK;
            n.rdata = 8'h00;
            case (s_axi_araddr[`SCS_IDX_HI:`SCS_IDX_LO])
                `SCS_HR_CTRL: n.rdata = {5'h00, s.cfg};
                `SCS_HR_TX: n.rdata = 8'h00;
                `SCS_HR_RX: n.rdata = s.rxData;
                `SCS_HR_STAT: n.rdata = {5'h00, s.sticky, s.fsm != H_IDLE};
                `SCS_HR_MASK: n.rdata = {5'h00, s.mask, 1'h0};
                default: n.rresp = `SCS_RESP_ERR;
            endcase
        end
        n.awready = !n.awTaken && !n.bvalid;
        n.wready = !n.wTaken && !n.bvalid;
        n.arready = !n.rvalid;
        if (n.fsm == H_IDLE || n.fsm == H_GAP) begin
            n.sclk = n.cfg.cpol;
        end
        selAct = (n.fsm == H_SETUP) || (n.fsm == H_SHIFT) || (n.fsm == H_HOLD);
        n.sselPin = n.cfg.sselHigh ? selAct : ~selAct;
        // set wins over a clear in the same cycle
        n.sticky = (s.sticky & ~clr) | evt;
        n.irq = |(n.sticky & n.mask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.fsm <= H_IDLE;
            // reset returns to the device's default format
            s.cfg <= `SCS_CFG_RST;
            s.sselPin <= 1'h1;
            s.awready <= 1'h1;
            s.wready <= 1'h1;
            s.arready <= 1'h1;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = {24'h000000, s.rdata};
    assign irq = s.irq;
    assign link.sclk = s.sclk;
    assign link.ssel = s.sselPin;
    assign link.mosi = s.mosi;
endmodule : scs_host

/* File: bench/scs_link_asserts.sv */
// concurrent checks on the serial link between host and device ends
module scs_link_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic ssel,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic irqN
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // link counters
    // ----------------------------------------
    logic sclk_ff;
    logic [4:0] edgeCnt_ff;
    logic [7:0] lowCnt_ff;
    logic [8:0] gapCnt_ff;
    // gap counter saturates so the first byte after reset passes
    always_ff @(posedge ref_clk) begin
        sclk_ff <= sclk;
        edgeCnt_ff <= (rst || ssel) ? 5'h0 : edgeCnt_ff + {4'h0, sclk != sclk_ff};
        lowCnt_ff <= (rst || ssel) ? 8'h0 : lowCnt_ff + 8'h1;
        gapCnt_ff <= rst ? 9'h1FF : !ssel ? 9'h000 : gapCnt_ff + {8'h00, gapCnt_ff != 9'h1FF};
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sclk_quiet;
        $stable(sclk) [*5];
    endsequence
    chk_reset_idle: assert property (
        $fell(rst) |-> ssel && irqN && !sclk && !misoOe)
        else $error("link busy after reset");
    chk_byte_edges: assert property (
        $rose(ssel) |-> edgeCnt_ff == 5'h10)
        else $error("byte without sixteen clock edges");
    chk_select_span: assert property (
        $rose(ssel) |-> lowCnt_ff == 8'hB4)
        else $error("select span wrong");
    chk_first_edge: assert property (
        $fell(ssel) |-> sclk_quiet ##1 sclk_quiet ##1 sclk_quiet ##1 sclk_quiet ##1 $changed(sclk))
        else $error("first clock edge misplaced");
    chk_gap_kept: assert property (
        $fell(ssel) |-> gapCnt_ff >= 9'h190)
        else $error("gap between bytes too short");
    chk_miso_release: assert property (
        ssel [*8] |-> !misoOe)
        else $error("data out driven while deselected");
    chk_mosi_on_edge: assert property (
        !ssel && $changed(mosi) |-> $changed(sclk) || $fell(ssel))
        else $error("data in moved off a clock edge");
    chk_miso_settled: assert property (
        !ssel && $changed(sclk) |=> $stable(misoOut) [*2])
        else $error("data out moved next to an edge");
endmodule : scs_link_asserts

/* File: bench/tb.sv */
// self-checking bench joining host and device ends of the serial link
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scs_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic porRst = 1'h1;
    logic oscInputPin = 1'h0;
    logic userEvent = 1'h0;
    logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, respQ;
    logic [31:0] s_axi_rdata;
    scs_cfg_t activeCfg;
    logic externalClockSelect, lowPowerMode, oscEnable, sysClkHf, rxValid;
    logic [7:0] rxByte;
    int bad_count = 0;
    int num_checks = 0;
    int rxCount = 0;
    scs_link_if scs_link_if_i ();
    scs_device #(.WARM_CYC(16)) scs_device_i (.ref_clk, .rst, .porRst, .oscInputPin,
        .userEvent, .link(scs_link_if_i), .activeCfg, .externalClockSelect, .lowPowerMode,
        .oscEnable, .sysClkHf, .rxByte, .rxValid);
    scs_host #(.HALF_CYC(10), .GAP_CYC(400)) scs_host_i (.ref_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq, .link(scs_link_if_i));
    scs_link_asserts scs_link_asserts_i (.ref_clk, .rst, .sclk(scs_link_if_i.sclk),
        .ssel(scs_link_if_i.ssel), .mosi(scs_link_if_i.mosi),
        .misoOut(scs_link_if_i.misoOut), .misoOe(scs_link_if_i.misoOe),
        .irqN(scs_link_if_i.irqN));
    always #4 ref_clk = !ref_clk;
    // received-byte strobe lasts one cycle, so count it as it happens
    always @(posedge ref_clk) rxCount <= rxValid ? rxCount + 1 : rxCount;
    // ----------------------------------------
    // bus and link tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask : axw
    task automatic axr(input logic [4:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        respQ = s_axi_rresp;
    endtask : axr
    // busy stays up through the gap, so wait for idle before the next byte
    task automatic xfer(input logic [7:0] tx, input logic [7:0] expRx);
        logic [31:0] d;
        int c;
        c = rxCount;
        axw(5'h04, tx, 2'h0);
        do axr(5'h0C, d); while (d[1] !== 1'h1);
        chk(rxByte, tx);
        chk(rxCount, c + 1);
        axr(5'h08, d);
        chk(d, expRx);
        axw(5'h0C, 8'h02, 2'h0);
        do axr(5'h0C, d); while (d[0] !== 1'h0);
    endtask : xfer
    task automatic dop(input logic wr, input logic [11:0] a, input logic [7:0] v);
        xfer({wr, 3'h0, a[11:8]}, 8'hC1);
        xfer(a[7:0], 8'hC2);
        xfer(wr ? v : 8'h00, 8'h41);
        if (!wr) xfer(8'h00, v);
    endtask : dop
    // porRst only together with rst: the checker only knows rst
    task automatic pulse(input logic por);
        @(posedge ref_clk);
        rst <= 1'h1;
        porRst <= por;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        porRst <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask : pulse
    task automatic osc(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge ref_clk);
            oscInputPin <= !oscInputPin;
        end
        repeat (10) @(posedge ref_clk);
    endtask : osc
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        chk(activeCfg, 3'h0);
        axr(5'h00, d);
        chk(d, 32'h0);
        axr(5'h14, d);
        chk(respQ, 2'h2);
        axw(5'h08, 8'h5A, 2'h2);
        dop(1'h0, 12'h011, 8'h00);
        chk(sysClkHf, 1'h0);
    endtask : t_reset
    task automatic t_clock;
        osc(15);
        chk(sysClkHf, 1'h0);
        osc(1);
        chk(sysClkHf, 1'h1);
        dop(1'h1, 12'h012, 8'h02);
        chk(lowPowerMode, 1'h1);
        chk(sysClkHf, 1'h0);
        dop(1'h1, 12'h012, 8'h00);
        chk(sysClkHf, 1'h1);
    endtask : t_clock
    task automatic t_format;
        logic [2:0] m;
        for (int i = 1; i < 5; i++) begin
            m = {1'h0, i[1:0]};
            dop(1'h1, 12'h010, {5'h0, m});
            // new format takes over right after the address byte
            xfer(8'h09, 8'hC1);
            xfer(8'h00, 8'hC2);
            chk(activeCfg, m);
            axw(5'h00, {5'h0, m}, 2'h0);
            xfer(8'h00, 8'h41);
            xfer(8'h00, 8'h00);
            dop(1'h0, 12'h011, {5'h0, m});
        end
    endtask : t_format
    task automatic t_irq;
        logic [31:0] d;
        dop(1'h1, 12'h014, 8'h01);
        @(posedge ref_clk);
        userEvent <= 1'h1;
        @(posedge ref_clk);
        userEvent <= 1'h0;
        repeat (8) @(posedge ref_clk);
        chk(scs_link_if_i.irqN, 1'h0);
        axr(5'h0C, d);
        chk(d[2], 1'h1);
        chk(irq, 1'h0);
        axw(5'h10, 8'h04, 2'h0);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'h1);
        dop(1'h1, 12'h013, 8'h01);
        chk(scs_link_if_i.irqN, 1'h1);
        axw(5'h0C, 8'h04, 2'h0);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'h0);
    endtask : t_irq
    task automatic t_external_clock_select;
        dop(1'h1, 12'h012, 8'h10);
        chk(externalClockSelect, 1'h1);
        chk(oscEnable, 1'h0);
        pulse(1'h0);
        chk(externalClockSelect, 1'h1);
        chk(sysClkHf, 1'h0);
        pulse(1'h1);
        chk(externalClockSelect, 1'h0);
        chk(oscEnable, 1'h1);
    endtask : t_external_clock_select
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        pulse(1'h1);
        t_reset();
        t_clock();
        t_format();
        t_irq();
        t_external_clock_select();
        conclude();
    end
    initial begin
        #600000;
        bad_count++;
        conclude();
    end
endmodule : tb
